/* shared/sarctl_defines.svh */
`ifndef SARCTL_DEFINES_SVH
`define SARCTL_DEFINES_SVH

// ************************************************************
// Widths
// ************************************************************
`define SARCTL_RESULT_W      12
`define SARCTL_IDX_W         4
`define SARCTL_MSB_IDX       4'hb

// ************************************************************
// Reset values
// ************************************************************
`define SARCTL_RESULT_RST    12'h000
`define SARCTL_IDX_RST       4'h0

// ************************************************************
// Timing
// ************************************************************
`define SARCTL_CLK_MHZ        250
`define SARCTL_DATA_SETUP_NS 70
// Longest time, so the cycle count rounds down
`define SARCTL_DATA_SETUP_CYC \
    ((`SARCTL_DATA_SETUP_NS * `SARCTL_CLK_MHZ) / 1000)

`endif

/* shared/sarctl_pkg.sv */
package sarctl_pkg;

    // ************************************************************
    // Converter sequencing states
    // ************************************************************
    typedef enum logic [1:0] {
        IDLE,
        WAIT_BEGIN,
        CONVERT
    } sarctl_state_t;

endpackage

/* verilog/sarctl_osc_port.sv */
`timescale 1ns/10ps
`include "sarctl_defines.svh"

module sarctl_osc_port (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic oscIn,
    output logic      oscOut,
    output logic      oscFall
);

    logic oscPrev;

    // ************************************************************
    // Oscillator sampling
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscPrev <= 1'b0;
            oscOut  <= 1'b1;
        end else begin
            oscPrev <= oscIn;
            oscOut  <= ~oscIn;
        end
    end

    // Falling edge of the conversion clock, one cycle wide
    assign oscFall = oscPrev & ~oscIn;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_osc_inverse;
        @(posedge clk) disable iff (!rst_n)
        $changed(oscIn) |=> (oscOut != $past(oscOut))
            && (oscOut == ~oscPrev);
    endproperty
    a_osc_inverse: assert property (p_osc_inverse)
        else $error("oscillator output is not the inverse of its input");

endmodule

/* verilog/sarctl_top.sv */
`timescale 1ns/10ps
`include "sarctl_defines.svh"

module sarctl_top (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         selectN,
    input  wire logic                         readN,
    input  wire logic                         oscIn,
    input  wire logic                         compIn,
    output logic                              oscOut,
    output logic                              busyN,
    output logic [`SARCTL_RESULT_W-1:0]       result_bus,
    output logic                              resultOe,
    output logic [`SARCTL_RESULT_W-1:0]       dacCode
);

    localparam int DataSetupCyc = `SARCTL_DATA_SETUP_CYC;

    sarctl_pkg::sarctl_state_t         state;
    sarctl_pkg::sarctl_state_t         next_state;
    logic                              readPrev;
    logic                              oscFall;
    logic [`SARCTL_IDX_W-1:0]          bitIdx;
    logic [`SARCTL_IDX_W-1:0]          next_bitIdx;
    logic [`SARCTL_RESULT_W-1:0]       approximation_register;
    logic [`SARCTL_RESULT_W-1:0]       next_approx;
    logic [`SARCTL_RESULT_W-1:0]       decided;
    logic                              next_busyN;
    logic                              next_oe;
    logic                              loadLatch;
    wire                               startReq;
    wire                               idle;
    wire                               decideEdge;
    wire                               lastBit;

    // One-hot mask for a bit position
    function automatic logic [`SARCTL_RESULT_W-1:0] bitMask(
        input logic [`SARCTL_IDX_W-1:0] idx
    );
        bitMask = `SARCTL_RESULT_W'(1) << idx;
    endfunction

    // ************************************************************
    // Oscillator port
    // ************************************************************
    sarctl_osc_port sarctl_osc_port_inst (
        .clk     (clk),
        .rst_n   (rst_n),
        .oscIn   (oscIn),
        .oscOut  (oscOut),
        .oscFall (oscFall)
    );

    // ************************************************************
    // Start decode and sequencing
    // ************************************************************
    // Read falling while select is low; select alone does nothing
    assign startReq   = ~selectN & ~readN & readPrev;
    assign idle       = (state == sarctl_pkg::IDLE);
    assign decideEdge = (state == sarctl_pkg::CONVERT) & oscFall;
    assign lastBit    = (bitIdx == `SARCTL_IDX_RST);
    // Keep the trial bit when the comparator says input is above DAC
    assign decided    = compIn ? approximation_register
                               : approximation_register & ~bitMask(bitIdx);
    assign next_oe    = ~selectN & ~readN;

    always_comb begin
        next_state  = state;
        next_bitIdx = bitIdx;
        next_approx = approximation_register;
        next_busyN  = busyN;
        loadLatch   = 1'b0;
        unique case (state)
            sarctl_pkg::IDLE: begin
                if (startReq) begin
                    next_state  = sarctl_pkg::WAIT_BEGIN;
                    next_approx = `SARCTL_RESULT_RST;
                    next_busyN  = 1'b0;
                end
            end
            sarctl_pkg::WAIT_BEGIN: begin
                // Unsynchronised start waits up to one oscillator period
                if (oscFall) begin
                    next_state  = sarctl_pkg::CONVERT;
                    next_bitIdx = `SARCTL_MSB_IDX;
                    next_approx = bitMask(`SARCTL_MSB_IDX);
                end
            end
            sarctl_pkg::CONVERT: begin
                if (oscFall) begin
                    if (lastBit) begin
                        next_state  = sarctl_pkg::IDLE;
                        next_approx = decided;
                        next_busyN  = 1'b1;
                        loadLatch   = 1'b1;
                    end else begin
                        next_bitIdx = bitIdx - `SARCTL_IDX_W'(1);
                        next_approx = decided | bitMask(next_bitIdx);
                    end
                end
            end
        endcase
    end

    // ************************************************************
    // State registers
    // ************************************************************
    // Further starts are simply not decoded outside idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state    <= sarctl_pkg::IDLE;
            bitIdx   <= `SARCTL_IDX_RST;
            readPrev <= 1'b1;
        end else begin
            state    <= next_state;
            bitIdx   <= next_bitIdx;
            readPrev <= readN;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            approximation_register <= `SARCTL_RESULT_RST;
            dacCode                <= `SARCTL_RESULT_RST;
        end else begin
            approximation_register <= next_approx;
            dacCode                <= next_approx;
        end
    end

    // ************************************************************
    // Bus side
    // ************************************************************
    // The latch is the bus driver itself: the previous result stays
    // visible through a held read until the new one loads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busyN      <= 1'b1;
            resultOe   <= 1'b0;
            result_bus <= `SARCTL_RESULT_RST;
        end else begin
            busyN    <= next_busyN;
            resultOe <= next_oe;
            if (loadLatch) begin
                result_bus <= decided;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_bus_off_unselected;
        @(posedge clk) disable iff (!rst_n)
        (selectN || readN) |=> !resultOe;
    endproperty
    a_bus_off_unselected: assert property (p_bus_off_unselected)
        else $error("result bus enabled without select and read");

    property p_bus_on_selected;
        @(posedge clk) disable iff (!rst_n)
        (!selectN && !readN) |=> resultOe;
    endproperty
    a_bus_on_selected: assert property (p_bus_on_selected)
        else $error("result bus not enabled under select and read");

    property p_start_busy;
        @(posedge clk) disable iff (!rst_n)
        (idle && $fell(readN) && !selectN) |=> !busyN && (dacCode == 0);
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("qualified read did not start a conversion");

    property p_read_needs_select;
        @(posedge clk) disable iff (!rst_n)
        (idle && busyN && selectN) |=> busyN;
    endproperty
    a_read_needs_select: assert property (p_read_needs_select)
        else $error("conversion started without select");

    property p_busy_in_conv;
        @(posedge clk) disable iff (!rst_n)
        (state != sarctl_pkg::IDLE) |-> !busyN;
    endproperty
    a_busy_in_conv: assert property (p_busy_in_conv)
        else $error("busy high while converting");

    property p_no_restart;
        @(posedge clk) disable iff (!rst_n)
        (state == sarctl_pkg::CONVERT && startReq && !oscFall)
            |=> (state == sarctl_pkg::CONVERT) && $stable(bitIdx);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("running conversion was restarted");

    property p_begin_edge;
        @(posedge clk) disable iff (!rst_n)
        (state == sarctl_pkg::WAIT_BEGIN && oscFall)
            |=> (state == sarctl_pkg::CONVERT) && (bitIdx == 4'hb)
                && (approximation_register == 12'h800);
    endproperty
    a_begin_edge: assert property (p_begin_edge)
        else $error("bit sequence did not begin at first falling edge");

    property p_bit_step;
        @(posedge clk) disable iff (!rst_n)
        (decideEdge && !lastBit) |=> (bitIdx == $past(bitIdx) - 4'h1);
    endproperty
    a_bit_step: assert property (p_bit_step)
        else $error("bit index did not step down by one");

    property p_latch_on_end;
        @(posedge clk) disable iff (!rst_n)
        $rose(busyN) |-> (result_bus == approximation_register);
    endproperty
    a_latch_on_end: assert property (p_latch_on_end)
        else $error("finished result not copied into the latch");

    property p_data_after_busy;
        @(posedge clk) disable iff (!rst_n)
        $rose(busyN) |-> ##[0:DataSetupCyc] (result_bus == dacCode);
    endproperty
    a_data_after_busy: assert property (p_data_after_busy)
        else $error("result not valid in time after busy rose");

    property p_hold_old;
        @(posedge clk) disable iff (!rst_n)
        (!busyN && !$rose(busyN)) |=> $stable(result_bus) || $rose(busyN);
    endproperty
    a_hold_old: assert property (p_hold_old)
        else $error("latch changed before the conversion finished");

endmodule

/* bench/sarctl_host.sv */
`timescale 1ns/10ps

// ********
// Host bus master
// ********
module sarctl_host (
    input  wire logic clk,
    input  wire logic busyN,
    output logic      selectN,
    output logic      readN
);
    initial begin
        selectN = 1'b1;
        readN   = 1'b1;
    end

    // Read that starts a conversion; optional second strobe mid-run
    task automatic readConv(input bit again, input int lag, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clk);
        #1 selectN = 1'b0;
        readN = 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busyN !== 1'b0 && n < 8);
        if (busyN !== 1'b0) return;
        if (again) begin
            repeat (30) @(posedge clk);
            #1 readN = 1'b1;
            @(posedge clk);
            #1 readN = 1'b0;
        end
        n = 0;
        while (busyN !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        ok = (busyN === 1'b1);
        // Slow hosts keep the strobe low a while after the result
        repeat (lag + 1) @(posedge clk);
        #1 readN = 1'b1;
        @(posedge clk);
        #1 selectN = 1'b1;
    endtask

    // Read strobe while the device is not selected
    task automatic strayRead();
        @(posedge clk);
        #1 readN = 1'b0;
        repeat (20) @(posedge clk);
        #1 readN = 1'b1;
    endtask
endmodule

/* bench/sarctl_tb_top.sv */
`timescale 1ns/10ps
`include "sarctl_defines.svh"

module sarctl_tb_top;
    localparam int W = `SARCTL_RESULT_W;
    // Oscillator period in system clocks; conversions span 12 to 13 of them
    localparam int OscCyc = 8;
    logic         clk, rst_n, oscIn, selectN, readN;
    logic         oscOut, busyN, resultOe, compIn, ok, again;
    logic         selNow, rdNow, oscNow, rstNow, busyPrev, lenOk;
    logic [W-1:0] result_bus, dacCode, ain, lastRes;
    logic [W-1:0] notes[$];
    logic [31:0]  seed;
    int           errors, tests_run, lowCnt;
    wire  [W-1:0] padBus;

    assign padBus = resultOe ? result_bus : {W{1'bz}};
    assign compIn = (ain >= dacCode);

    sarctl_top sarctl_top_inst (
        .clk(clk), .rst_n(rst_n), .selectN(selectN), .readN(readN),
        .oscIn(oscIn), .compIn(compIn), .oscOut(oscOut), .busyN(busyN),
        .result_bus(result_bus), .resultOe(resultOe), .dacCode(dacCode)
    );

    sarctl_host sarctl_host_inst (
        .clk(clk), .busyN(busyN), .selectN(selectN), .readN(readN)
    );

    function automatic logic [W-1:0] b2w(input logic b);
        return {{(W-1){1'b0}}, b};
    endfunction

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input string what, input logic [W-1:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ********
    // Clock, oscillator and watchdog
    // ********
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        oscIn = 1'b1;
        forever begin
            repeat (OscCyc / 2) @(posedge clk);
            #1 oscIn = ~oscIn;
        end
    end

    // Ten conversions of about 110 cycles each fit well inside this
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim();
    end

    // ********
    // Output monitor
    // ********
    always @(posedge clk) begin
        selNow = selectN;
        rdNow  = readN;
        oscNow = oscIn;
        rstNow = rst_n;
        #2;
        if (rstNow === 1'b1) begin
            chk("oscOut", b2w(~oscNow), b2w(oscOut));
            chk("resultOe", b2w(~selNow&~rdNow), b2w(resultOe));
            if (busyPrev === 1'b1 && busyN === 1'b0) begin
                chk("noted", b2w(1'b1), b2w(notes.size() > 0));
                chk("dacLow", '0, dacCode);
                lowCnt = 0;
            end
            if (busyN === 1'b0) begin
                lowCnt++;
                chk("heldLatch", lastRes, result_bus);
            end
            if (busyPrev === 1'b0 && busyN === 1'b1) begin
                lenOk = lowCnt >= 12 * OscCyc && lowCnt <= 13 * OscCyc;
                chk("busyLen", b2w(1'b1), b2w(lenOk));
                if (notes.size() > 0) lastRes = notes.pop_front();
                chk("padBus", lastRes, padBus);
            end
            busyPrev = busyN;
        end
    end

    // ********
    // Stimulus
    // ********
    initial begin
        rst_n = 1'b0;
        ain = '0;
        lastRes = '0;
        seed = 32'h313e;
        errors = 0;
        tests_run = 0;
        lowCnt = 0;
        busyPrev = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        @(negedge clk);
        chk("rstBusy", b2w(1'b1), b2w(busyN));
        chk("rstOe", b2w(1'b0), b2w(resultOe));
        chk("rstLatch", '0, result_bus);
        $display("test reset done");
        // Boundary codes first, restart attempts in runs 3 and 7
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            again = (i == 3 || i == 7);
            @(posedge clk);
            #1 ain = (i == 0) ? '0 : (i == 1) ? '1 : seed[W-1:0];
            notes.push_back(ain);
            sarctl_host_inst.readConv(again, seed[17:16], ok);
            chk("convDone", b2w(1'b1), b2w(ok));
            $display("test conversion %0d done", i);
        end
        sarctl_host_inst.strayRead();
        @(negedge clk);
        chk("strayBusy", b2w(1'b1), b2w(busyN));
        $display("test unselected read done");
        end_sim();
    end
endmodule
